// >>> hw/ssd_pkg.sv
// Constants, types and register map of the start-up sequencer and range decoder.
// Assumes a 20 MHz system clock and an APB master on the register side.
// Notes on behaviour
// - main loop runs once every 7 ms; relay, pressure and solenoid checks and lever updates step on it; memory checks step every clock.
// - start-up runs on key to unlock or run, and after cranking.
// - relay energised only after memory, supply and pressure checks pass.
// - any failed check logs its code and enters limp-in at once.
// - crank input halts processing; start-up reruns when cranking ends with the key at run.
// - every writable memory word is pattern tested; failure logs code 17.
// - program memory checksum verified; failure logs code 16.
// - relay contacts must pass no current before energising; else code 14.
// - all three pressure switches must read open; else code 20.
// - relay closed then current checked; failure logs code 15.
// - each of four solenoid drivers checked; failures log codes 41 to 44.
// - after start-up clear working state, set lever to neutral, then run.
// - pressure checks suppressed for the first seconds of running.
// - four range circuits read as a code; a closed switch grounds it.
// - decoder gives P, R, N, D, 2, L, three transition codes or invalid.
// - R, P, N, first transition and D map straight to R, N or D.
// - 2, L, other transition and invalid codes follow hydraulic mode; in drive, transition and invalid codes also use current lever.
// - engine speed recomputed on every direct speed pulse.
// - direct engine speed is used for control, never the network value.
// - network engine speed only confirms the direct measurement.
package ssd_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned LOOP_US = 7000;
  localparam int unsigned LOOP_CYC = CLK_HZ / 1_000_000 * LOOP_US;
  localparam int unsigned SUPP_MS = 2000;
  localparam int unsigned SUPP_LOOPS = SUPP_MS * 1000 / LOOP_US;
  localparam int unsigned SETTLE_LOOPS = 2;
  localparam int unsigned RAM_WORDS = 16;
  // ----------------------------------------
  // Fault codes and sticky bit positions
  // ----------------------------------------
  localparam logic [7:0] FC_RELAY_STUCK = 8'h0e;
  localparam logic [7:0] FC_RELAY_DEAD = 8'h0f;
  localparam logic [7:0] FC_ROM = 8'h10;
  localparam logic [7:0] FC_RAM = 8'h11;
  localparam logic [7:0] FC_PRESS = 8'h14;
  localparam logic [7:0] FC_SOL0 = 8'h29;
  localparam int FB_RELAY_STUCK = 0;
  localparam int FB_RELAY_DEAD = 1;
  localparam int FB_ROM = 2;
  localparam int FB_RAM = 3;
  localparam int FB_PRESS = 4;
  localparam int FB_SOL0 = 5;
  localparam int FAULT_W = 9;
  // ----------------------------------------
  // Memory test data
  // ----------------------------------------
  localparam logic [63:0] ROM_IMG = 64'hf0debc9a78563412;
  localparam logic [7:0] ROM_SUM = 8'h38;
  localparam logic [7:0] PAT_A = 8'h55;
  localparam logic [7:0] PAT_B = 8'haa;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FAULT = 8'h08;
  localparam logic [7:0] REG_LASTCODE = 8'h0c;
  localparam logic [7:0] REG_LEVER = 8'h10;
  localparam logic [7:0] REG_ENG = 8'h14;
  localparam logic [7:0] REG_NET = 8'h18;
  localparam logic [15:0] NET_RST = 16'h0000;
  localparam logic [15:0] ENG_RST = 16'hffff;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_RAM = 4'h1, ST_ROM = 4'h3, ST_ROPEN = 4'h2,
    ST_PRESS = 4'h6, ST_RCLOSE = 4'h7, ST_SOL = 4'h5, ST_INIT = 4'h4,
    ST_RUN = 4'hc, ST_LIMP = 4'hd, ST_HALT = 4'hf
  } ssd_state_t;
  typedef enum logic [3:0] {
    RC_P = 4'h0, RC_R = 4'h1, RC_N = 4'h2, RC_D = 4'h3, RC_2 = 4'h4,
    RC_L = 4'h5, RC_TRN1 = 4'h6, RC_TRN2 = 4'h7, RC_TRN3 = 4'h8, RC_INV = 4'hf
  } ssd_range_t;
  typedef enum logic [2:0] {
    LV_N = 3'h0, LV_R = 3'h1, LV_D = 3'h2, LV_2 = 3'h3, LV_L = 3'h4
  } ssd_lever_t;
  typedef enum logic [1:0] {
    HM_NEUTRAL = 2'h0, HM_REVERSE = 2'h1, HM_DRIVE = 2'h2
  } ssd_hyd_t;
  typedef struct packed {
    logic key_acc;
    logic key_run;
    logic crank;
    logic relay_sense;
    logic [2:0] press_closed;
    logic [3:0] sol_ok;
    logic [3:0] range_n;
    logic eng_pulse;
  } ssd_pins_t;
endpackage

// >>> hw/ssd_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin levels; output moves only when stages two and three agree.
`timescale 1ns/10ps
module ssd_sync #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Hold while the two late stages disagree
      dout <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
    end
  end
endmodule

// >>> hw/ssd_range.sv
// Range switch decoder and lever position screen, purely combinational.
// Assumes synchronised active-low circuits and a hydraulic mode from speed-ratio logic.
`timescale 1ns/10ps
module ssd_range (
  input wire logic [3:0] range_n,
  input wire logic [2:0] press_closed,
  input ssd_pkg::ssd_hyd_t ratio_mode,
  input ssd_pkg::ssd_lever_t lever_cur,
  output ssd_pkg::ssd_range_t code,
  output ssd_pkg::ssd_lever_t lever_nxt
);
  logic [3:0] closed;
  ssd_pkg::ssd_hyd_t hyd;

  assign closed = ~range_n;

  always_comb
  begin
    case (closed)
      4'hc: code = ssd_pkg::RC_P;
      4'h3: code = ssd_pkg::RC_R;
      4'h6: code = ssd_pkg::RC_N;
      4'h1: code = ssd_pkg::RC_D;
      4'h2: code = ssd_pkg::RC_2;
      4'h8: code = ssd_pkg::RC_L;
      4'h4: code = ssd_pkg::RC_TRN1;
      4'h0: code = ssd_pkg::RC_TRN2;
      4'h9: code = ssd_pkg::RC_TRN3;
      default: code = ssd_pkg::RC_INV;
    endcase
  end

  // Pressure on a forward circuit overrides a neutral ratio reading
  always_comb
  begin
    hyd = ratio_mode;
    if (ratio_mode == ssd_pkg::HM_NEUTRAL && press_closed[2:1] != 2'b00)
      hyd = ssd_pkg::HM_DRIVE;
  end

  always_comb
  begin
    case (code)
      ssd_pkg::RC_R: lever_nxt = ssd_pkg::LV_R;
      ssd_pkg::RC_P, ssd_pkg::RC_N, ssd_pkg::RC_TRN1: lever_nxt = ssd_pkg::LV_N;
      ssd_pkg::RC_D: lever_nxt = ssd_pkg::LV_D;
      default:
      begin
        // Screened codes follow the hydraulic mode actually established
        case (hyd)
          ssd_pkg::HM_REVERSE: lever_nxt = ssd_pkg::LV_R;
          ssd_pkg::HM_DRIVE:
          begin
            if (code == ssd_pkg::RC_2)
              lever_nxt = ssd_pkg::LV_2;
            else if (code == ssd_pkg::RC_L)
              lever_nxt = ssd_pkg::LV_L;
            else if (lever_cur == ssd_pkg::LV_N || lever_cur == ssd_pkg::LV_R)
              lever_nxt = ssd_pkg::LV_D;
            else
              lever_nxt = lever_cur;
          end
          default: lever_nxt = ssd_pkg::LV_N;
        endcase
      end
    endcase
  end
endmodule

// >>> hw/ssd_top.sv
// Start-up self-test sequencer with range decode and engine speed capture.
// Assumes pins from outside the clock domain and an APB master for registers.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
module ssd_top #(
  parameter int LOOP_CYCLES = ssd_pkg::LOOP_CYC,
  parameter int SUPP_LOOPS = ssd_pkg::SUPP_LOOPS,
  parameter int SETTLE_LOOPS = ssd_pkg::SETTLE_LOOPS,
  parameter int RAM_DEPTH = ssd_pkg::RAM_WORDS
) (
  input wire logic clk_sys,
  input wire logic srst,
  input ssd_pkg::ssd_pins_t pins,
  input ssd_pkg::ssd_hyd_t ratio_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic relay_drive,
  output logic limp_mode,
  output logic loop_tick,
  output logic work_clear,
  output logic press_chk_en,
  output ssd_pkg::ssd_lever_t lever_position_output,
  output ssd_pkg::ssd_range_t decoded_range_code,
  output logic [15:0] eng_period
);
  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (LOOP_CYCLES < 2 || LOOP_CYCLES > 262143)
  begin : g_chk_loop
    $error("LOOP_CYCLES out of range");
  end
  if (RAM_DEPTH < 2 || RAM_DEPTH > 256 || SUPP_LOOPS > 65535 || SETTLE_LOOPS < 1)
  begin : g_chk_misc
    $error("Unsupported depth or loop count");
  end

  localparam int AW = $clog2(RAM_DEPTH);

  // ----------------------------------------
  // Pin capture
  // ----------------------------------------
  ssd_pkg::ssd_pins_t pin_s;
  ssd_sync #(.W($bits(ssd_pkg::ssd_pins_t))) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .din(pins),
    .dout(pin_s)
  );

  // ----------------------------------------
  // Main loop pacing
  // ----------------------------------------
  logic [17:0] loop_cnt_r;
  always_ff @(posedge clk_sys)
  begin
    if (srst || work_clear)
      loop_cnt_r <= '0;
    else if (loop_cnt_r == 18'(LOOP_CYCLES - 1))
      loop_cnt_r <= '0;
    else
      loop_cnt_r <= loop_cnt_r + 18'h1;
  end
  assign loop_tick = (loop_cnt_r == 18'(LOOP_CYCLES - 1));

  // ----------------------------------------
  // Start triggers
  // ----------------------------------------
  logic key_on;
  logic key_on_q_r;
  logic crank_q_r;
  logic soft_start;
  logic start_req;
  assign key_on = pin_s.key_acc | pin_s.key_run;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      key_on_q_r <= 1'b0;
      crank_q_r <= 1'b0;
    end
    else
    begin
      key_on_q_r <= key_on;
      crank_q_r <= pin_s.crank;
    end
  end
  assign start_req = (key_on & ~key_on_q_r)
                   | (crank_q_r & ~pin_s.crank & pin_s.key_run)
                   | (soft_start & key_on);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  ssd_pkg::ssd_state_t st_r;
  logic [AW-1:0] ram_addr_r;
  logic [1:0] ram_ph_r;
  logic [7:0] ram_mem [RAM_DEPTH];
  logic [2:0] rom_idx_r;
  logic [7:0] rom_sum_r;
  logic [1:0] sol_idx_r;
  logic [15:0] wait_r;
  logic fail;
  logic [7:0] fail_code;
  localparam int FAULT_W_L = ssd_pkg::FAULT_W;
  logic [FAULT_W_L-1:0] fail_bits;

  function automatic logic [7:0] rom_word(input logic [2:0] i);
    rom_word = ssd_pkg::ROM_IMG[{i, 3'b000} +: 8];
  endfunction

  // Failure decision for the current step
  always_comb
  begin
    fail = 1'b0;
    fail_code = 8'h00;
    fail_bits = '0;
    case (st_r)
      ssd_pkg::ST_RAM:
      begin
        if (ram_ph_r[0] && ram_mem[ram_addr_r] != (ram_ph_r[1] ? ssd_pkg::PAT_B : ssd_pkg::PAT_A))
        begin
          fail = 1'b1;
          fail_code = ssd_pkg::FC_RAM;
          fail_bits[ssd_pkg::FB_RAM] = 1'b1;
        end
      end
      ssd_pkg::ST_ROM:
      begin
        if (rom_idx_r == 3'h7 && 8'(rom_sum_r + rom_word(rom_idx_r)) != ssd_pkg::ROM_SUM)
        begin
          fail = 1'b1;
          fail_code = ssd_pkg::FC_ROM;
          fail_bits[ssd_pkg::FB_ROM] = 1'b1;
        end
      end
      ssd_pkg::ST_ROPEN:
      begin
        if (loop_tick && pin_s.relay_sense)
        begin
          fail = 1'b1;
          fail_code = ssd_pkg::FC_RELAY_STUCK;
          fail_bits[ssd_pkg::FB_RELAY_STUCK] = 1'b1;
        end
      end
      ssd_pkg::ST_PRESS:
      begin
        if (loop_tick && pin_s.press_closed != 3'b000)
        begin
          fail = 1'b1;
          fail_code = ssd_pkg::FC_PRESS;
          fail_bits[ssd_pkg::FB_PRESS] = 1'b1;
        end
      end
      ssd_pkg::ST_RCLOSE:
      begin
        if (loop_tick && wait_r == 16'h0000 && !pin_s.relay_sense)
        begin
          fail = 1'b1;
          fail_code = ssd_pkg::FC_RELAY_DEAD;
          fail_bits[ssd_pkg::FB_RELAY_DEAD] = 1'b1;
        end
      end
      ssd_pkg::ST_SOL:
      begin
        if (loop_tick && !pin_s.sol_ok[sol_idx_r])
        begin
          fail = 1'b1;
          fail_code = ssd_pkg::FC_SOL0 + {6'h00, sol_idx_r};
          fail_bits[ssd_pkg::FB_SOL0 + 32'(sol_idx_r)] = 1'b1;
        end
      end
      default:
      begin
        fail = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      st_r <= ssd_pkg::ST_IDLE;
    else if (pin_s.crank)
      st_r <= ssd_pkg::ST_HALT;
    else if (!key_on)
      st_r <= ssd_pkg::ST_IDLE;
    else if (start_req)
      st_r <= ssd_pkg::ST_RAM;
    else if (fail)
      st_r <= ssd_pkg::ST_LIMP;
    else
    begin
      case (st_r)
        ssd_pkg::ST_RAM:
          if (ram_ph_r == 2'h3 && ram_addr_r == AW'(RAM_DEPTH - 1))
            st_r <= ssd_pkg::ST_ROM;
        ssd_pkg::ST_ROM:
          if (rom_idx_r == 3'h7)
            st_r <= ssd_pkg::ST_ROPEN;
        ssd_pkg::ST_ROPEN:
          if (loop_tick)
            st_r <= ssd_pkg::ST_PRESS;
        ssd_pkg::ST_PRESS:
          if (loop_tick)
            st_r <= ssd_pkg::ST_RCLOSE;
        ssd_pkg::ST_RCLOSE:
          if (loop_tick && wait_r == 16'h0000)
            st_r <= ssd_pkg::ST_SOL;
        ssd_pkg::ST_SOL:
          if (loop_tick && sol_idx_r == 2'h3)
            st_r <= ssd_pkg::ST_INIT;
        ssd_pkg::ST_INIT:
          st_r <= ssd_pkg::ST_RUN;
        default:
          st_r <= st_r;
      endcase
    end
  end

  // Memory test walk: write A, check A, write B, check B per word
  always_ff @(posedge clk_sys)
  begin
    if (srst || st_r != ssd_pkg::ST_RAM)
    begin
      ram_addr_r <= '0;
      ram_ph_r <= 2'h0;
    end
    else
    begin
      ram_ph_r <= ram_ph_r + 2'h1;
      if (ram_ph_r == 2'h3)
        ram_addr_r <= ram_addr_r + AW'(1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (st_r == ssd_pkg::ST_RAM && !ram_ph_r[0])
      ram_mem[ram_addr_r] <= ram_ph_r[1] ? ssd_pkg::PAT_B : ssd_pkg::PAT_A;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || st_r != ssd_pkg::ST_ROM)
    begin
      rom_idx_r <= 3'h0;
      rom_sum_r <= 8'h00;
    end
    else
    begin
      rom_idx_r <= rom_idx_r + 3'h1;
      rom_sum_r <= 8'(rom_sum_r + rom_word(rom_idx_r));
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || st_r != ssd_pkg::ST_RCLOSE)
      wait_r <= 16'(SETTLE_LOOPS - 1);
    else if (loop_tick && wait_r != 16'h0000)
      wait_r <= wait_r - 16'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || st_r != ssd_pkg::ST_SOL)
      sol_idx_r <= 2'h0;
    else if (loop_tick)
      sol_idx_r <= sol_idx_r + 2'h1;
  end

  // Relay only after earlier checks; dropped on crank, fault or key off
  assign relay_drive = (st_r == ssd_pkg::ST_RCLOSE) || (st_r == ssd_pkg::ST_SOL)
                    || (st_r == ssd_pkg::ST_INIT) || (st_r == ssd_pkg::ST_RUN);
  assign limp_mode = (st_r == ssd_pkg::ST_LIMP);
  assign work_clear = (st_r == ssd_pkg::ST_INIT);

  // ----------------------------------------
  // Pressure check hold-off
  // ----------------------------------------
  logic [15:0] supp_r;
  always_ff @(posedge clk_sys)
  begin
    if (srst || work_clear)
      supp_r <= 16'(SUPP_LOOPS);
    else if (st_r == ssd_pkg::ST_RUN && loop_tick && supp_r != 16'h0000)
      supp_r <= supp_r - 16'h1;
  end
  assign press_chk_en = (st_r == ssd_pkg::ST_RUN) && (supp_r == 16'h0000);

  // ----------------------------------------
  // Range decode and lever position
  // ----------------------------------------
  ssd_pkg::ssd_lever_t lever_nxt;
  ssd_range u_range (
    .range_n(pin_s.range_n),
    .press_closed(pin_s.press_closed),
    .ratio_mode(ratio_mode),
    .lever_cur(lever_position_output),
    .code(decoded_range_code),
    .lever_nxt(lever_nxt)
  );
  always_ff @(posedge clk_sys)
  begin
    if (srst || work_clear)
      lever_position_output <= ssd_pkg::LV_N;
    else if (loop_tick && (st_r == ssd_pkg::ST_RUN || st_r == ssd_pkg::ST_LIMP))
      lever_position_output <= lever_nxt;
  end

  // ----------------------------------------
  // Engine speed from the direct pulse
  // ----------------------------------------
  logic eng_q_r;
  logic [15:0] eng_cnt_r;
  logic [15:0] net_period_r;
  logic eng_bad;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      eng_q_r <= 1'b0;
    else
      eng_q_r <= pin_s.eng_pulse;
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst || work_clear)
    begin
      eng_cnt_r <= 16'h0000;
      eng_period <= ssd_pkg::ENG_RST;
    end
    else if (pin_s.eng_pulse && !eng_q_r)
    begin
      eng_period <= eng_cnt_r;
      eng_cnt_r <= 16'h0000;
    end
    else if (eng_cnt_r != 16'hffff)
      eng_cnt_r <= eng_cnt_r + 16'h1;
  end
  // Network value only cross-checks; it never drives eng_period
  always_comb
  begin
    if (net_period_r == 16'h0000)
      eng_bad = 1'b0;
    else if (eng_period > net_period_r)
      eng_bad = (eng_period - net_period_r) > {2'b00, net_period_r[15:2]};
    else
      eng_bad = (net_period_r - eng_period) > {2'b00, net_period_r[15:2]};
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic wr_en;
  logic [FAULT_W_L-1:0] fault_r;
  logic [7:0] last_code_r;
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;
  assign soft_start = wr_en && paddr == ssd_pkg::REG_CTRL && pwdata[0];

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      net_period_r <= ssd_pkg::NET_RST;
    else if (wr_en && paddr == ssd_pkg::REG_NET)
      net_period_r <= pwdata[15:0];
  end

  // Sticky faults: a new failure wins over a write-one clear
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      fault_r <= '0;
      last_code_r <= 8'h00;
    end
    else
    begin
      if (wr_en && paddr == ssd_pkg::REG_FAULT)
        fault_r <= (fault_r & ~pwdata[FAULT_W_L-1:0]) | fail_bits;
      else
        fault_r <= fault_r | fail_bits;
      if (fail)
        last_code_r <= fail_code;
    end
  end

  function automatic logic mapped(input logic [7:0] a);
    mapped = a == ssd_pkg::REG_CTRL || a == ssd_pkg::REG_STATUS
          || a == ssd_pkg::REG_FAULT || a == ssd_pkg::REG_LASTCODE
          || a == ssd_pkg::REG_LEVER || a == ssd_pkg::REG_ENG || a == ssd_pkg::REG_NET;
  endfunction

  assign pslverr = psel & penable & ~mapped(paddr);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        ssd_pkg::REG_STATUS:
          prdata <= {22'h000000, eng_bad, press_chk_en, st_r == ssd_pkg::ST_RUN,
                     relay_drive, limp_mode, 1'b0, st_r};
        ssd_pkg::REG_FAULT: prdata <= {23'h000000, fault_r};
        ssd_pkg::REG_LASTCODE: prdata <= {24'h000000, last_code_r};
        ssd_pkg::REG_LEVER:
          prdata <= {25'h0000000, lever_position_output, decoded_range_code};
        ssd_pkg::REG_ENG: prdata <= {16'h0000, eng_period};
        ssd_pkg::REG_NET: prdata <= {16'h0000, net_period_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// >>> dv/ssd_top_props.sv
// Port checker for the start-up sequencer, bound into every ssd_top.
// Assumes one clock domain and the synchronous reset of the design.
`timescale 1ns/10ps
module ssd_top_props #(
  parameter int LOOP_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic srst,
  input ssd_pkg::ssd_pins_t pins,
  input ssd_pkg::ssd_hyd_t ratio_mode,
  input wire logic relay_drive,
  input wire logic limp_mode,
  input wire logic loop_tick,
  input wire logic work_clear,
  input wire logic press_chk_en,
  input ssd_pkg::ssd_lever_t lever_position_output,
  input ssd_pkg::ssd_range_t decoded_range_code
);
  int gap;
  logic seen;
  // ------
  // Helpers
  // ------
  always_ff @(posedge clk_sys)
  begin
    if (srst || loop_tick || work_clear)
      gap <= 0;
    else
      gap <= gap + 1;
  end
  // First tick after reset has no reference, so it is not measured
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      seen <= 1'b0;
    else if (loop_tick)
      seen <= 1'b1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_run_tick;
    loop_tick && press_chk_en;
  endsequence
  sequence s_fail_step;
    loop_tick ##1 $rose(limp_mode);
  endsequence
  // ------
  // Properties
  // ------
  tick_gap_a: assert property (loop_tick && seen |-> gap == LOOP_CYCLES - 1)
    else $error("loop tick spacing wrong");
  relay_limp_a: assert property (limp_mode |-> !relay_drive && !press_chk_en)
    else $error("relay on in limp-in");
  limp_rise_a: assert property ($rose(limp_mode) |-> $past(loop_tick))
    else $error("limp-in entered off a loop tick");
  relay_rise_a: assert property ($rose(relay_drive) |-> $past(loop_tick))
    else $error("relay closed off a loop tick");
  crank_halt_a: assert property (pins.crank [*6] |-> !relay_drive && !work_clear)
    else $error("relay held during cranking");
  init_lever_a: assert property (work_clear |=> lever_position_output == ssd_pkg::LV_N)
    else $error("lever not neutral after start-up");
  press_hold_a: assert property (work_clear |=> !press_chk_en [*3])
    else $error("pressure checks not held off");
  rev_lever_a: assert property (s_run_tick ##0 decoded_range_code == ssd_pkg::RC_R
    |=> lever_position_output == ssd_pkg::LV_R) else $error("reverse not taken");
  mode_lever_a: assert property (s_run_tick ##0 (decoded_range_code == ssd_pkg::RC_2
    && ratio_mode == ssd_pkg::HM_REVERSE) |=> lever_position_output == ssd_pkg::LV_R)
    else $error("second in reverse mode not screened");
  open_code_a: assert property (pins.range_n == 4'hf [*5] |->
    decoded_range_code == ssd_pkg::RC_TRN2) else $error("all-open not decoded");
  fail_c: cover property (s_fail_step);
endmodule
bind ssd_top ssd_top_props #(.LOOP_CYCLES(LOOP_CYCLES)) props_u (.clk_sys(clk_sys),
  .srst(srst), .pins(pins), .ratio_mode(ratio_mode), .relay_drive(relay_drive),
  .limp_mode(limp_mode), .loop_tick(loop_tick), .work_clear(work_clear),
  .press_chk_en(press_chk_en), .lever_position_output(lever_position_output),
  .decoded_range_code(decoded_range_code));

// >>> dv/ssd_plant.sv
// Relay contacts, pressure switches and solenoid returns around the sequencer.
// Assumes fault knobs are set by the bench between start-ups.
`timescale 1ns/10ps
module ssd_plant (
  input wire logic relay_drive,
  input wire logic stuck,
  input wire logic dead,
  input wire logic press_bad,
  input wire logic [3:0] sol_bad,
  output logic relay_sense,
  output logic [2:0] press_closed,
  output logic [3:0] sol_ok
);
  assign relay_sense = stuck || (relay_drive && !dead);
  assign press_closed = press_bad ? 3'h2 : 3'h0;
  // Open feed means no continuity on any return
  assign sol_ok = relay_drive ? ~sol_bad : 4'h0;
endmodule

// >>> dv/ssd_top_test.sv
// Self-checking bench for the start-up sequencer over APB.
// Assumes ssd_top, ssd_plant and the bound checker are compiled first.
`timescale 1ns/10ps
module ssd_top_test;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic key_acc = 1'b0, key_run = 1'b0, crank = 1'b0, eng_pulse = 1'b0;
  logic stuck = 1'b0, dead = 1'b0, press_bad = 1'b0;
  logic [3:0] range_n = 4'hf, sol_bad = 4'h0, sol_ok;
  ssd_pkg::ssd_hyd_t ratio_mode = ssd_pkg::HM_NEUTRAL;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, relay_drive, limp_mode, loop_tick, work_clear, press_chk_en, relay_sense;
  logic [2:0] press_closed;
  logic [15:0] eng_period;
  ssd_pkg::ssd_lever_t lever;
  ssd_pkg::ssd_range_t code;
  ssd_pkg::ssd_pins_t pins;
  int n_errors = 0, tests_run = 0;
  localparam logic [6:0] KNOB [5] = '{7'h40, 7'h20, 7'h10, 7'h01, 7'h08};
  localparam logic [31:0] FBIT [5] = '{32'h1, 32'h2, 32'h10, 32'h20, 32'h100};
  localparam logic [31:0] FCODE [5] = '{32'h0e, 32'h0f, 32'h14, 32'h29, 32'h2c};
  localparam logic [15:0] RTAB [10] = '{16'h3000, 16'hc011, 16'h9002, 16'he023,
    16'hb006, 16'hd114, 16'h7245, 16'hf007, 16'h6118, 16'h011f};
  assign pins = {key_acc, key_run, crank, relay_sense, press_closed, sol_ok, range_n, eng_pulse};
  always #25 clk_sys = ~clk_sys;
  ssd_top #(.LOOP_CYCLES(20), .SUPP_LOOPS(3)) dut_u (.clk_sys(clk_sys), .srst(srst),
    .pins(pins), .ratio_mode(ratio_mode), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .relay_drive(relay_drive), .limp_mode(limp_mode), .loop_tick(loop_tick),
    .work_clear(work_clear), .press_chk_en(press_chk_en), .lever_position_output(lever),
    .decoded_range_code(code), .eng_period(eng_period));
  ssd_plant plant_u (.relay_drive(relay_drive), .stuck(stuck), .dead(dead),
    .press_bad(press_bad), .sol_bad(sol_bad), .relay_sense(relay_sense),
    .press_closed(press_closed), .sol_ok(sol_ok));
  // ------
  // Tasks
  // ------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_done();
    for (int i = 0; i < 3000 && limp_mode !== 1'b1 && press_chk_en !== 1'b1; i++)
      @(posedge clk_sys);
    n_errors += int'(limp_mode !== 1'b1 && press_chk_en !== 1'b1);
  endtask
  // Key off first so every run starts from idle
  task automatic startup();
    key_acc <= 1'b0;
    key_run <= 1'b0;
    repeat (8) @(posedge clk_sys);
    key_acc <= 1'b1;
    key_run <= 1'b1;
    repeat (8) @(posedge clk_sys);
    wait_done();
  endtask
  task automatic tick();
    @(posedge clk_sys);
    while (loop_tick !== 1'b1)
      @(posedge clk_sys);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ------
  // Tests
  // ------
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, ssd_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, ssd_pkg::REG_ENG, 32'h0);
    chk(rd, 32'hffff);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset and map test done");
    for (int i = 0; i < 5; i++)
    begin
      {stuck, dead, press_bad, sol_bad} <= KNOB[i];
      startup();
      apb(1'b0, ssd_pkg::REG_FAULT, 32'h0);
      chk(rd, FBIT[i]);
      apb(1'b0, ssd_pkg::REG_LASTCODE, 32'h0);
      chk(rd, FCODE[i]);
      apb(1'b1, ssd_pkg::REG_FAULT, 32'h1ff);
      apb(1'b0, ssd_pkg::REG_FAULT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, ssd_pkg::REG_STATUS, 32'h0);
      chk(rd, 32'h2d);
    end
    $display("fault test done");
    {stuck, dead, press_bad, sol_bad} <= 7'h00;
    startup();
    apb(1'b0, ssd_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h1cc);
    for (int i = 0; i < 10; i++)
    begin
      range_n <= RTAB[i][15:12];
      ratio_mode <= ssd_pkg::ssd_hyd_t'(RTAB[i][9:8]);
      tick();
      tick();
      apb(1'b0, ssd_pkg::REG_LEVER, 32'h0);
      chk(rd, {24'h0, RTAB[i][7:0]});
    end
    $display("range test done");
    repeat (4)
    begin
      eng_pulse <= 1'b1;
      repeat (5) @(posedge clk_sys);
      eng_pulse <= 1'b0;
      repeat (5) @(posedge clk_sys);
    end
    apb(1'b0, ssd_pkg::REG_ENG, 32'h0);
    chk(rd, 32'h0009);
    apb(1'b1, ssd_pkg::REG_NET, 32'h5);
    apb(1'b0, ssd_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h3cc);
    apb(1'b0, ssd_pkg::REG_ENG, 32'h0);
    chk(rd, 32'h0009);
    $display("speed test done");
    crank <= 1'b1;
    repeat (10) @(posedge clk_sys);
    apb(1'b0, ssd_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h20f);
    crank <= 1'b0;
    repeat (8) @(posedge clk_sys);
    wait_done();
    apb(1'b0, ssd_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'h1ff, 32'h1cc);
    apb(1'b1, ssd_pkg::REG_CTRL, 32'h1);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, press_chk_en}, 32'h0);
    wait_done();
    apb(1'b0, ssd_pkg::REG_STATUS, 32'h0);
    chk(rd & 32'h1ff, 32'h1cc);
    $display("crank and restart test done");
    close_out();
  end
endmodule
